//--- core/down_timer_pkg.sv
// Constants, register map and bus carrier for one down-counter timer channel.
// Assumes a single clock shared by register access and counting.
//
// Notes on behaviour
// - Reset leaves counter off, free-running, 16-bit, divide 1, irq enabled, load 0, count ones.
// - Mode bit clear selects free-running, set selects periodic; free-running after reset.
// - Count steps only when enabled, qualifier high and the prescaler pulses.
// - Free-running 32-bit: interrupt at zero, wrap to all ones, load value ignored.
// - Free-running 16-bit: low half counts, interrupt at zero, wraps to 0xffff.
// - Disable freezes the count; re-enable resumes from the frozen value.
// - Periodic: at zero raise interrupt, reload from load value, keep counting.
// - Load write replaces the count at once; the next qualified edge passes without a step.
// - Deferred load write updates load value only; used at next and later reloads.
// - Single-run bit selects one-shot and overrides the mode bit.
// - One-shot: interrupt at zero, then counting stops.
// - Load write in one-shot retriggers the countdown at once; stepping resumes after the next qualified edge.
// - Width bit picks 32 or 16 bits; 16-bit ignores upper half for zero.
// - Interrupt is raised from a qualified counting clock edge.
// - Mask enable gates the output; raw and masked status are both readable.
// - Prescaler divides the qualified rate by 1, 16 or 256 from a two-bit field.
// - Interval is qualifier divisor times prescale times load plus one, or two to the width.
// - Load of zero raises an interrupt at the next qualified edge; software should load at least one.
// - Present count is readable at any time in every mode.
// - After a load write the count reads back the new value immediately.
`default_nettype none
package down_timer_pkg;

   // ==========================================================
   // Bus shape
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;

   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFS_RELOAD_VALUE = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CURRENT_COUNT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CHANNEL_CONTROL = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLEAR = 8'h0c;
   localparam logic [ADDR_W-1:0] OFS_RAW_IRQ_STATUS = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_MASKED_IRQ_STATUS = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_DEFERRED_RELOAD = 8'h18;

   // ==========================================================
   // Control field positions
   localparam int CTL_COUNT_ENABLE_BIT = 7;
   localparam int CTL_RELOAD_MODE_BIT = 6;
   localparam int CTL_IRQ_MASK_ENABLE_BIT = 5;
   localparam int CTL_PRESCALE_HI = 3;
   localparam int CTL_PRESCALE_LO = 2;
   localparam int CTL_WIDTH_BIT = 1;
   localparam int CTL_SINGLE_RUN_BIT = 0;
   localparam int CTL_W = 8;

   // ==========================================================
   // Prescale encodings
   localparam logic [1:0] PRE_DIV1 = 2'h0;
   localparam logic [1:0] PRE_DIV16 = 2'h1;
   localparam logic [1:0] PRE_DIV256 = 2'h2;
   localparam int PRESCALE_W = 8;
   localparam logic [PRESCALE_W-1:0] PRE16_LAST = 8'h0f;
   localparam logic [PRESCALE_W-1:0] PRE256_LAST = 8'hff;

   // ==========================================================
   // Reset values
   localparam logic [CTL_W-1:0] RST_CONTROL = 8'h20;
   localparam logic [DATA_W-1:0] RST_RELOAD = 32'h00000000;
   localparam logic [DATA_W-1:0] RST_COUNT = 32'hffffffff;
   localparam logic [15:0] WRAP16 = 16'hffff;
   localparam logic [DATA_W-1:0] WRAP32 = 32'hffffffff;

endpackage : down_timer_pkg
`default_nettype wire

//--- core/down_timer_channel.sv
// One down-counter timer channel with its register slave.
// Assumes the counting clock equals clk_in and that the qualifier input is
// driven by logic on the same clock, so it is not synchronised.
`timescale 1ns/100ps
`default_nettype none
module down_timer_channel (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire down_timer_pkg::bus_req_t bus_in,
   output logic [down_timer_pkg::DATA_W-1:0] rdata_out,
   input wire logic count_clock_qualifier_in,
   output logic channel_irq_out
);
   import down_timer_pkg::*;

   // ==========================================================
   // Reset release
   logic rst_meta_q;
   logic rst_sync_q;
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end
   wire rst_n = rst_sync_q;

   // ==========================================================
   // Address decode
   wire wr_reload = bus_in.wr && (bus_in.addr == OFS_RELOAD_VALUE);
   wire wr_control = bus_in.wr && (bus_in.addr == OFS_CHANNEL_CONTROL);
   wire wr_clear = bus_in.wr && (bus_in.addr == OFS_IRQ_CLEAR);
   wire wr_deferred = bus_in.wr && (bus_in.addr == OFS_DEFERRED_RELOAD);

   // ==========================================================
   // State
   logic [CTL_W-1:0] control_q;
   logic [DATA_W-1:0] reload_q;
   logic [DATA_W-1:0] count_q;
   logic [DATA_W-1:0] count_d;
   logic load_pend_q;
   logic [PRESCALE_W-1:0] pre_q;
   logic raw_irq_q;
   logic [DATA_W-1:0] rdata_q;

   wire count_en = control_q[CTL_COUNT_ENABLE_BIT];
   wire periodic = control_q[CTL_RELOAD_MODE_BIT];
   wire mask_en = control_q[CTL_IRQ_MASK_ENABLE_BIT];
   wire [1:0] pre_sel = control_q[CTL_PRESCALE_HI:CTL_PRESCALE_LO];
   wire wide = control_q[CTL_WIDTH_BIT];
   wire single_run = control_q[CTL_SINGLE_RUN_BIT];

   // Zero and one tests honour the selected width
   function automatic logic is_val(input logic [DATA_W-1:0] v, input logic w32, input logic [15:0] k);
      is_val = w32 ? (v == {16'h0000, k}) : (v[15:0] == k);
   endfunction : is_val

   // ==========================================================
   // Prescaler
   wire qual = count_clock_qualifier_in;
   wire pre_pulse = (pre_sel == PRE_DIV16) ? (pre_q[3:0] == PRE16_LAST[3:0]) :
                    (pre_sel == PRE_DIV256) ? (pre_q == PRE256_LAST) : 1'b1;
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         pre_q <= '0;
      end else if (qual) begin
         pre_q <= pre_q + 8'h01;
      end
   end

   // ==========================================================
   // Counter
   wire at_zero = is_val(count_q, wide, 16'h0000);
   wire at_one = is_val(count_q, wide, 16'h0001);
   // A pending load claims the next qualified edge without stepping
   wire pend_edge = qual && load_pend_q;
   wire tick = count_en && qual && pre_pulse && !load_pend_q;
   wire stop_here = single_run && at_zero;
   wire reach_zero = (tick && at_one) || (pend_edge && at_zero);

   always_comb begin
      count_d = count_q;
      if (wr_reload) begin
         count_d = bus_in.wdata;
      end else if (tick && !stop_here) begin
         if (at_zero) begin
            if (periodic && !single_run) begin
               count_d = reload_q;
            end else if (wide) begin
               count_d = WRAP32;
            end else begin
               count_d = {count_q[31:16], WRAP16};
            end
         end else if (wide) begin
            count_d = count_q - 32'h00000001;
         end else begin
            count_d = {count_q[31:16], count_q[15:0] - 16'h0001};
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         control_q <= RST_CONTROL;
         reload_q <= RST_RELOAD;
         count_q <= RST_COUNT;
         load_pend_q <= 1'b0;
      end else begin
         if (wr_control) begin
            control_q <= bus_in.wdata[CTL_W-1:0];
         end
         if (wr_reload || wr_deferred) begin
            reload_q <= bus_in.wdata;
         end
         count_q <= count_d;
         if (wr_reload) begin
            load_pend_q <= 1'b1;
         end else if (qual) begin
            load_pend_q <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Interrupt flag, set wins over clear
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         raw_irq_q <= 1'b0;
      end else if (reach_zero) begin
         raw_irq_q <= 1'b1;
      end else if (wr_clear) begin
         raw_irq_q <= 1'b0;
      end
   end
   assign channel_irq_out = raw_irq_q && mask_en;

   // ==========================================================
   // Read data, one cycle after the strobe
   wire [DATA_W-1:0] rd_mux =
      (bus_in.addr == OFS_RELOAD_VALUE) ? reload_q :
      (bus_in.addr == OFS_DEFERRED_RELOAD) ? reload_q :
      (bus_in.addr == OFS_CURRENT_COUNT) ? count_q :
      (bus_in.addr == OFS_CHANNEL_CONTROL) ? {24'h000000, control_q} :
      (bus_in.addr == OFS_RAW_IRQ_STATUS) ? {31'h00000000, raw_irq_q} :
      (bus_in.addr == OFS_MASKED_IRQ_STATUS) ? {31'h00000000, channel_irq_out} : 32'h00000000;
   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= '0;
      end else if (bus_in.rd) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= '0;
      end
   end
   assign rdata_out = rdata_q;

endmodule : down_timer_channel
`default_nettype wire

//--- verif/qual_source.sv
// Qualifier source standing where the counting-clock gating logic sits.
// Assumes the bench opens the gate for a known number of cycles.
`timescale 1ns/100ps
`default_nettype none
module qual_source (
   input wire logic clk_in,
   input wire logic gate_in,
   input wire logic pulsed_in,
   output logic qual_out
);
   logic ph_q;
   // ==========
   // Pulsed pattern enables every second edge of a burst
   always_ff @(posedge clk_in) ph_q <= gate_in ? ~ph_q : 1'b1;
   assign qual_out = gate_in & (ph_q | ~pulsed_in);
endmodule : qual_source
`default_nettype wire

//--- verif/down_timer_properties.sv
// Port assertions for one timer channel.
// Assumes bus and counting share clk_in.
`timescale 1ns/100ps
`default_nettype none
module down_timer_properties (
   input wire logic clk_in,
   input wire logic arst_n_in,
   input wire down_timer_pkg::bus_req_t bus_in,
   input wire logic [down_timer_pkg::DATA_W-1:0] rdata_out,
   input wire logic count_clock_qualifier_in,
   input wire logic channel_irq_out
);
   import down_timer_pkg::*;
   // ==========
   // Bus and interrupt relations
   default clocking @(posedge clk_in); endclocking
   default disable iff (!arst_n_in);
   wire logic clr_w = bus_in.wr && bus_in.addr == OFS_IRQ_CLEAR;
   wire logic ctl_w = bus_in.wr && bus_in.addr == OFS_CHANNEL_CONTROL;
   clear_drops_a: assert property (clr_w && !count_clock_qualifier_in |=> !channel_irq_out)
      else $error("irq stayed after clear");
   irq_holds_a: assert property (channel_irq_out && !clr_w && !ctl_w |=> channel_irq_out)
      else $error("irq dropped alone");
   irq_source_a: assert property ($rose(channel_irq_out) |-> $past(count_clock_qualifier_in) || $past(ctl_w))
      else $error("irq rose without cause");
   masked_read_a: assert property (bus_in.rd && bus_in.addr == OFS_MASKED_IRQ_STATUS
      |=> rdata_out == {31'h0, $past(channel_irq_out)}) else $error("masked status wrong");
   raw_read_a: assert property (bus_in.rd && bus_in.addr == OFS_RAW_IRQ_STATUS && channel_irq_out
      |=> rdata_out == 32'h1) else $error("raw status wrong");
   load_shows_a: assert property (bus_in.wr && bus_in.addr == OFS_RELOAD_VALUE ##1
      bus_in.rd && bus_in.addr == OFS_CURRENT_COUNT |=> rdata_out == $past(bus_in.wdata, 2))
      else $error("count not new load");
   deferred_load_a: assert property (bus_in.wr && bus_in.addr == OFS_DEFERRED_RELOAD ##1
      bus_in.rd && bus_in.addr == OFS_RELOAD_VALUE |=> rdata_out == $past(bus_in.wdata, 2))
      else $error("load not updated");
   idle_zero_a: assert property (!$past(bus_in.rd) |-> rdata_out == 32'h0)
      else $error("read data outside slot");
endmodule : down_timer_properties
`default_nettype wire

//--- verif/dual_down_counter_timer_test.sv
// Self-checking bench for one timer channel.
// Assumes the qualifier source model and the property checker.
`timescale 1ns/100ps
`default_nettype none
module dual_down_counter_timer_test;
   import down_timer_pkg::*;
   logic clk_in = 1'b0;
   logic arst_n_in = 1'b0;
   logic gate = 1'b0;
   logic pulsed = 1'b0;
   logic qual;
   logic irq;
   logic raw;
   bus_req_t bus = '0;
   logic [31:0] rdata, v, ld, ld2;
   logic [7:0] c;
   int num_errors = 0;
   int n_tests = 0;
   int seed = 32'h7e47;
   int n;
   always #2.5 clk_in = ~clk_in;
   down_timer_channel down_timer_channel_i (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_in(bus),
      .rdata_out(rdata), .count_clock_qualifier_in(qual), .channel_irq_out(irq));
   qual_source qual_source_i (.clk_in(clk_in), .gate_in(gate), .pulsed_in(pulsed), .qual_out(qual));
   // ==========
   // Tasks and model
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      bus.wr <= 1'b0;
   endtask : wr
   task automatic rd_check(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge clk_in);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      bus.rd <= 1'b0;
      #1 check(rdata, exp, what);
   endtask : rd_check
   // Write followed by a read in the very next cycle, no idle gap
   task automatic wr_rd(input logic [7:0] wa, input logic [31:0] d, input logic [7:0] ra,
      input logic [31:0] exp, input string what);
      @(posedge clk_in);
      bus <= '{addr: wa, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      bus <= '{addr: ra, wdata: d, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      bus.rd <= 1'b0;
      #1 check(rdata, exp, what);
   endtask : wr_rd
   task automatic burst(input int k);
      @(posedge clk_in);
      gate <= 1'b1;
      repeat (k) @(posedge clk_in);
      gate <= 1'b0;
   endtask : burst
   function automatic logic [32:0] model(logic [31:0] x, int k, logic [7:0] m, logic [31:0] re);
      logic r;
      r = 1'b0;
      repeat (k) begin
         if (m[1] ? x == 0 : x[15:0] == 0) begin
            if (!m[0]) x = m[6] ? re : m[1] ? 32'hffffffff : {x[31:16], 16'hffff};
         end else begin
            x = m[1] ? x - 32'h1 : {x[31:16], x[15:0] - 16'h1};
            r |= m[1] ? x == 0 : x[15:0] == 0;
         end
      end
      return {r, x};
   endfunction : model
   // ==========
   // Scenarios
   initial begin
      repeat (8) @(posedge clk_in);
      arst_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      rd_check(OFS_CHANNEL_CONTROL, 32'h20, "ctl");
      rd_check(OFS_CURRENT_COUNT, 32'hffffffff, "cnt");
      rd_check(OFS_RELOAD_VALUE, 32'h0, "load");
      rd_check(8'hfc, 32'h0, "gap");
      $display("reset test done");
      for (int i = 0; i < 24; i++) begin
         c = 8'h80 | (8'($random(seed)) & 8'h63);
         ld = (32'($random(seed)) & 32'h0003001f) | 32'h1;
         ld2 = (32'($random(seed)) & 32'h1f) | 32'h1;
         n = ($random(seed) & 63) + 1;
         wr(OFS_IRQ_CLEAR, 32'h0);
         wr(OFS_CHANNEL_CONTROL, {24'h0, c});
         wr_rd(OFS_RELOAD_VALUE, ld, OFS_CURRENT_COUNT, ld, "load");
         if (i[0]) wr_rd(OFS_DEFERRED_RELOAD, ld2, OFS_RELOAD_VALUE, ld2, "deferred"); else ld2 = ld;
         rd_check(OFS_CURRENT_COUNT, ld, "start");
         burst(n);
         {raw, v} = model(ld, n - 1, c, ld2);
         rd_check(OFS_CURRENT_COUNT, v, "count");
         rd_check(OFS_MASKED_IRQ_STATUS, {31'h0, raw & c[5]}, "masked");
         check({31'h0, irq}, {31'h0, raw & c[5]}, "irq");
      end
      $display("mode test done");
      pulsed <= 1'b1;
      wr(OFS_CHANNEL_CONTROL, 32'hc2);
      wr(OFS_RELOAD_VALUE, 32'h100);
      burst(8);
      wr(OFS_CHANNEL_CONTROL, 32'h42);
      burst(8);
      rd_check(OFS_CURRENT_COUNT, 32'hfd, "frozen");
      wr(OFS_CHANNEL_CONTROL, 32'hc2);
      burst(8);
      rd_check(OFS_CURRENT_COUNT, 32'hf9, "resumed");
      pulsed <= 1'b0;
      wr(OFS_CHANNEL_CONTROL, 32'hc6);
      wr(OFS_RELOAD_VALUE, 32'h1000);
      burst(257);
      rd_check(OFS_CURRENT_COUNT, 32'hff0, "div16");
      wr(OFS_CHANNEL_CONTROL, 32'hca);
      wr(OFS_RELOAD_VALUE, 32'h1000);
      burst(257);
      rd_check(OFS_CURRENT_COUNT, 32'hfff, "div256");
      $display("freeze and prescale test done");
      wr(OFS_IRQ_CLEAR, 32'h0);
      wr(OFS_CHANNEL_CONTROL, 32'he2);
      wr(OFS_RELOAD_VALUE, 32'h0);
      burst(1);
      rd_check(OFS_RAW_IRQ_STATUS, 32'h1, "zero load");
      wr(OFS_IRQ_CLEAR, 32'hffffffff);
      #1 check({31'h0, irq}, 32'h0, "cleared");
      rd_check(OFS_RAW_IRQ_STATUS, 32'h0, "raw clear");
      $display("clear test done");
      wr(OFS_CHANNEL_CONTROL, 32'he3);
      wr(OFS_RELOAD_VALUE, 32'h3);
      burst(2);
      wr_rd(OFS_RELOAD_VALUE, 32'h5, OFS_CURRENT_COUNT, 32'h5, "retrigger");
      burst(7);
      rd_check(OFS_CURRENT_COUNT, 32'h0, "single stop");
      rd_check(OFS_MASKED_IRQ_STATUS, 32'h1, "single irq");
      $display("one-shot test done");
      tally_and_finish();
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      num_errors++;
      tally_and_finish();
   end
endmodule : dual_down_counter_timer_test
bind down_timer_channel down_timer_properties down_timer_properties_i (.clk_in(clk_in), .arst_n_in(arst_n_in),
   .bus_in(bus_in), .rdata_out(rdata_out), .count_clock_qualifier_in(count_clock_qualifier_in),
   .channel_irq_out(channel_irq_out));
`default_nettype wire
